// ==== src/rsc_bus_edges.sv ====
// Purpose: clock edges, start and stop conditions of the two-wire bus
// Assumes: inputs already synchronised to ref_clk
// Notes:   outputs are one-cycle pulses
`timescale 1ns/1ps
module rsc_bus_edges (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclLvl,
  input wire logic sdaLvl,
  output logic sclRise,
  output logic sclFall,
  output logic startCond,
  output logic stopCond
);

  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
  } rsc_edge_t;

  rsc_edge_t q_r;
  rsc_edge_t q_nxt;

  always_comb begin
    q_nxt.sclPrev = sclLvl;
    q_nxt.sdaPrev = sdaLvl;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= {rsc_pkg::LINE_IDLE, rsc_pkg::LINE_IDLE};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sclRise = sclLvl & ~q_r.sclPrev;
  assign sclFall = ~sclLvl & q_r.sclPrev;
  // data moving while the clock is high marks a frame boundary
  assign startCond = sclLvl & q_r.sclPrev & q_r.sdaPrev & ~sdaLvl;
  assign stopCond = sclLvl & q_r.sclPrev & ~q_r.sdaPrev & sdaLvl;

endmodule : rsc_bus_edges

// ==== src/rsc_command_decode.sv ====
// Purpose: serial command front end of a real-time clock
// Assumes: ref_clk 200 MHz; bus clock far slower (bench 160 ns period)
// Notes:   time keeping, pin waveforms and supply detection live outside
//
// How it works
// - device answers only code 0110
// - command field picks one of eight groups
// - calendar is seven masked BCD bytes, year first
// - time access is hour, minute, second bytes
// - pin A alarm mode uses three enable-topped bytes
// - pin B alarm mode uses three enable-topped bytes
// - frequency mode is one byte, rates low
// - spare rate bits stored, no interrupt effect
// - writing init bit reinitialises the device
// - two free user bits in mode flags
// - pin event flags read-only, cleared on read
// - power-on and supply-drop flags clear on read
// - reserved bits ignore writes, read zero
// - trim and user bytes are plain bytes
// - hour format bit: 0 twelve, 1 twenty-four
// - data bytes travel least significant bit first
`timescale 1ns/1ps
module rsc_command_decode (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic pinAEvent,
  input wire logic pinBEvent,
  input wire logic supplyDrop,
  output logic deviceInit,
  output logic [7:0] modeFlags,
  output logic [7:0] interruptMode,
  output logic [55:0] calendarTime,
  output logic [23:0] pinAAlarm,
  output logic [23:0] pinBAlarm,
  output logic [7:0] pinAFreq,
  output logic [7:0] pinBFreq,
  output logic [7:0] rateTrim,
  output logic [7:0] userByte
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_state_t st;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [3:0] cnt;
    logic [2:0] cmd;
    logic rw;
    logic [2:0] idx;
    logic nack;
    logic oe;
    logic powerOnFlag;
    logic supplyDropFlag;
    logic pinBFlag;
    logic pinAFlag;
    logic userBitHi;
    logic userBitLo;
    logic hour24;
    logic [7:0] intMode;
    logic [6:0][7:0] cal;
    logic [2:0][7:0] almA;
    logic [2:0][7:0] almB;
    logic [7:0] freqA;
    logic [7:0] freqB;
    logic [7:0] trim;
    logic [7:0] user;
    logic initReq;
  } rsc_regs_t;

  rsc_regs_t q_r;
  rsc_regs_t q_nxt;

  logic sclLvl;
  logic sdaLvl;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  rsc_pin_sync #(.RST_LVL(rsc_pkg::LINE_IDLE)) u_scl_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(sclPin),
    .pinLvl(sclLvl)
  );

  rsc_pin_sync #(.RST_LVL(rsc_pkg::LINE_IDLE)) u_sda_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(sdaPin),
    .pinLvl(sdaLvl)
  );

  rsc_bus_edges u_edges (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sclLvl(sclLvl),
    .sdaLvl(sdaLvl),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startCond(startCond),
    .stopCond(stopCond)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  function automatic logic freqMode(input logic me, input logic fe);
    freqMode = ~me & fe;
  endfunction : freqMode

  function automatic logic alarmMode(input logic ae, input logic me,
                                     input logic fe);
    alarmMode = ae & ~me & ~fe;
  endfunction : alarmMode

  // byte presented to the master for command c, position i
  function automatic logic [7:0] readByte(input rsc_regs_t r,
                                          input logic [2:0] c,
                                          input logic [2:0] i);
    logic [2:0] t;
    t = 3'(i + rsc_pkg::TIME_FIRST);
    readByte = rsc_pkg::BYTE_RESET;
    unique case (c)
      rsc_pkg::CMD_STAT1: begin
        // init bit reads as zero
        if (i == 3'h0) begin
          readByte = {r.powerOnFlag, r.supplyDropFlag, r.pinBFlag,
                      r.pinAFlag, r.userBitHi, r.userBitLo, r.hour24,
                      1'b0};
        end
      end
      rsc_pkg::CMD_STAT2: begin
        if (i == 3'h0) readByte = r.intMode;
      end
      rsc_pkg::CMD_CAL: begin
        if (i < rsc_pkg::CAL_BYTES) readByte = r.cal[i];
      end
      rsc_pkg::CMD_TIME: begin
        if (i < rsc_pkg::TIME_BYTES) readByte = r.cal[t];
      end
      rsc_pkg::CMD_ALMA: begin
        if (freqMode(r.intMode[rsc_pkg::S2_A_MINUTE],
                     r.intMode[rsc_pkg::S2_A_FREQ])) begin
          if (i == 3'h0) readByte = r.freqA;
        end else if (i < rsc_pkg::ALARM_BYTES) begin
          readByte = r.almA[i];
        end
      end
      rsc_pkg::CMD_ALMB: begin
        if (freqMode(r.intMode[rsc_pkg::S2_B_MINUTE],
                     r.intMode[rsc_pkg::S2_B_FREQ])) begin
          if (i == 3'h0) readByte = r.freqB;
        end else if (i < rsc_pkg::ALARM_BYTES) begin
          readByte = r.almB[i];
        end
      end
      rsc_pkg::CMD_TRIM: begin
        if (i == 3'h0) readByte = r.trim;
      end
      rsc_pkg::CMD_USER: begin
        if (i == 3'h0) readByte = r.user;
      end
    endcase
  endfunction : readByte

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] nextIdx;
    logic [2:0] timeIdx;
    logic [7:0] b;
    nextIdx = (q_r.idx == 3'h7) ? q_r.idx : 3'(q_r.idx + 3'h1);
    timeIdx = 3'(q_r.idx + rsc_pkg::TIME_FIRST);
    b = q_r.sh;
    q_nxt = q_r;
    q_nxt.initReq = 1'b0;

    unique case (q_r.st)
      rsc_pkg::ST_IDLE, rsc_pkg::ST_IGNORE: begin
        q_nxt.oe = 1'b0;
      end
      rsc_pkg::ST_ADDR: begin
        if (sclRise) begin
          q_nxt.sh = {q_r.sh[6:0], sdaLvl};
          q_nxt.cnt = 4'(q_r.cnt + 4'h1);
        end else if (sclFall && q_r.cnt == rsc_pkg::BITS_PER_BYTE) begin
          if (q_r.sh[7:4] == rsc_pkg::DEV_CODE) begin
            q_nxt.cmd = q_r.sh[3:1];
            q_nxt.rw = q_r.sh[0];
            q_nxt.idx = 3'h0;
            q_nxt.oe = 1'b1;
            q_nxt.st = rsc_pkg::ST_ADDR_ACK;
          end else begin
            q_nxt.st = rsc_pkg::ST_IGNORE;
          end
        end
      end
      rsc_pkg::ST_ADDR_ACK: begin
        if (sclFall) begin
          q_nxt.cnt = 4'h0;
          if (q_r.rw) begin
            q_nxt.tx = readByte(q_r, q_r.cmd, 3'h0);
            q_nxt.oe = ~q_nxt.tx[0];
            q_nxt.st = rsc_pkg::ST_READ;
            if (q_r.cmd == rsc_pkg::CMD_STAT1) begin
              q_nxt.powerOnFlag = 1'b0;
              q_nxt.supplyDropFlag = 1'b0;
              q_nxt.pinBFlag = 1'b0;
              q_nxt.pinAFlag = 1'b0;
            end
          end else begin
            q_nxt.oe = 1'b0;
            q_nxt.st = rsc_pkg::ST_WRITE;
          end
        end
      end
      rsc_pkg::ST_WRITE: begin
        if (sclRise) begin
          q_nxt.sh = {sdaLvl, q_r.sh[7:1]};
          q_nxt.cnt = 4'(q_r.cnt + 4'h1);
        end else if (sclFall && q_r.cnt == rsc_pkg::BITS_PER_BYTE) begin
          q_nxt.oe = 1'b1;
          q_nxt.st = rsc_pkg::ST_WRITE_ACK;
          unique case (q_r.cmd)
            rsc_pkg::CMD_STAT1: begin
              if (q_r.idx == 3'h0) begin
                q_nxt.userBitHi = b[rsc_pkg::S1_USER_HI];
                q_nxt.userBitLo = b[rsc_pkg::S1_USER_LO];
                q_nxt.hour24 = b[rsc_pkg::S1_HOUR24];
                q_nxt.initReq = b[rsc_pkg::S1_INIT];
              end
            end
            rsc_pkg::CMD_STAT2: begin
              if (q_r.idx == 3'h0) q_nxt.intMode = b;
            end
            rsc_pkg::CMD_CAL: begin
              if (q_r.idx < rsc_pkg::CAL_BYTES) begin
                q_nxt.cal[q_r.idx] = b & rsc_pkg::CAL_MASK[q_r.idx];
              end
            end
            rsc_pkg::CMD_TIME: begin
              if (q_r.idx < rsc_pkg::TIME_BYTES) begin
                q_nxt.cal[timeIdx] = b & rsc_pkg::CAL_MASK[timeIdx];
              end
            end
            rsc_pkg::CMD_ALMA: begin
              if (freqMode(q_r.intMode[rsc_pkg::S2_A_MINUTE],
                           q_r.intMode[rsc_pkg::S2_A_FREQ])) begin
                if (q_r.idx == 3'h0) q_nxt.freqA = b;
              end else if (q_r.idx < rsc_pkg::ALARM_BYTES) begin
                q_nxt.almA[q_r.idx] = b & rsc_pkg::ALARM_MASK[q_r.idx];
              end
            end
            rsc_pkg::CMD_ALMB: begin
              if (freqMode(q_r.intMode[rsc_pkg::S2_B_MINUTE],
                           q_r.intMode[rsc_pkg::S2_B_FREQ])) begin
                if (q_r.idx == 3'h0) q_nxt.freqB = b;
              end else if (q_r.idx < rsc_pkg::ALARM_BYTES) begin
                q_nxt.almB[q_r.idx] = b & rsc_pkg::ALARM_MASK[q_r.idx];
              end
            end
            rsc_pkg::CMD_TRIM: begin
              if (q_r.idx == 3'h0) q_nxt.trim = b;
            end
            rsc_pkg::CMD_USER: begin
              if (q_r.idx == 3'h0) q_nxt.user = b;
            end
          endcase
        end
      end
      rsc_pkg::ST_WRITE_ACK: begin
        if (sclFall) begin
          q_nxt.oe = 1'b0;
          q_nxt.cnt = 4'h0;
          q_nxt.idx = nextIdx;
          q_nxt.st = rsc_pkg::ST_WRITE;
        end
      end
      rsc_pkg::ST_READ: begin
        if (sclRise) begin
          q_nxt.cnt = 4'(q_r.cnt + 4'h1);
        end else if (sclFall) begin
          if (q_r.cnt == rsc_pkg::BITS_PER_BYTE) begin
            q_nxt.oe = 1'b0;
            q_nxt.nack = 1'b0;
            q_nxt.st = rsc_pkg::ST_READ_ACK;
          end else begin
            q_nxt.tx = {1'b0, q_r.tx[7:1]};
            q_nxt.oe = ~q_r.tx[1];
          end
        end
      end
      rsc_pkg::ST_READ_ACK: begin
        if (sclRise) begin
          q_nxt.nack = sdaLvl;
        end else if (sclFall) begin
          if (q_r.nack) begin
            q_nxt.st = rsc_pkg::ST_IGNORE;
          end else begin
            q_nxt.idx = nextIdx;
            q_nxt.cnt = 4'h0;
            q_nxt.tx = readByte(q_r, q_r.cmd, nextIdx);
            q_nxt.oe = ~q_nxt.tx[0];
            q_nxt.st = rsc_pkg::ST_READ;
          end
        end
      end
    endcase

    // frame boundaries override any byte in progress
    if (startCond) begin
      q_nxt.st = rsc_pkg::ST_ADDR;
      q_nxt.cnt = 4'h0;
      q_nxt.oe = 1'b0;
    end else if (stopCond) begin
      q_nxt.st = rsc_pkg::ST_IDLE;
      q_nxt.oe = 1'b0;
    end

    // one cycle after the init write, all registers return to zero
    if (q_r.initReq) begin
      q_nxt.powerOnFlag = 1'b0;
      q_nxt.supplyDropFlag = 1'b0;
      q_nxt.pinBFlag = 1'b0;
      q_nxt.pinAFlag = 1'b0;
      q_nxt.userBitHi = 1'b0;
      q_nxt.userBitLo = 1'b0;
      q_nxt.hour24 = 1'b0;
      q_nxt.intMode = rsc_pkg::BYTE_RESET;
      q_nxt.cal = '0;
      q_nxt.almA = '0;
      q_nxt.almB = '0;
      q_nxt.freqA = rsc_pkg::BYTE_RESET;
      q_nxt.freqB = rsc_pkg::BYTE_RESET;
      q_nxt.trim = rsc_pkg::BYTE_RESET;
      q_nxt.user = rsc_pkg::BYTE_RESET;
    end

    // events set last so a read-clear in the same cycle cannot lose them
    if (supplyDrop) q_nxt.supplyDropFlag = 1'b1;
    if (pinAEvent && alarmMode(q_r.intMode[rsc_pkg::S2_A_ALARM],
                               q_r.intMode[rsc_pkg::S2_A_MINUTE],
                               q_r.intMode[rsc_pkg::S2_A_FREQ])) begin
      q_nxt.pinAFlag = 1'b1;
    end
    if (pinBEvent && alarmMode(q_r.intMode[rsc_pkg::S2_B_ALARM],
                               q_r.intMode[rsc_pkg::S2_B_MINUTE],
                               q_r.intMode[rsc_pkg::S2_B_FREQ])) begin
      q_nxt.pinBFlag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.st <= rsc_pkg::ST_IDLE;
      q_r.powerOnFlag <= rsc_pkg::POWER_ON_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = q_r.oe;
  assign deviceInit = q_r.initReq;
  assign modeFlags = {q_r.powerOnFlag, q_r.supplyDropFlag, q_r.pinBFlag,
                      q_r.pinAFlag, q_r.userBitHi, q_r.userBitLo,
                      q_r.hour24, 1'b0};
  assign interruptMode = q_r.intMode;
  assign calendarTime = q_r.cal;
  assign pinAAlarm = q_r.almA;
  assign pinBAlarm = q_r.almB;
  assign pinAFreq = q_r.freqA;
  assign pinBFreq = q_r.freqB;
  assign rateTrim = q_r.trim;
  assign userByte = q_r.user;

endmodule : rsc_command_decode

// ==== src/rsc_pin_sync.sv ====
// Purpose: three-flop synchroniser for a pin from outside ref_clk
// Assumes: pin is asynchronous to ref_clk
// Notes:   level follows only when the second and third flops agree
`timescale 1ns/1ps
module rsc_pin_sync #(
  parameter logic RST_LVL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic pinLvl
);

  typedef struct packed {
    logic [2:0] stage;
    logic lvl;
  } rsc_sync_t;

  rsc_sync_t q_r;
  rsc_sync_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.stage = {q_r.stage[1:0], pinIn};
    // stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
    if (q_r.stage[1] == q_r.stage[2]) begin
      q_nxt.lvl = q_r.stage[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= {{3{RST_LVL}}, RST_LVL};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pinLvl = q_r.lvl;

endmodule : rsc_pin_sync

// ==== src/rsc_pkg.sv ====
// Purpose: constants and types shared by the serial command decoder
// Assumes: one clock, ref_clk at 200 MHz
// Notes:   register bytes are 8 bits; multi-byte groups are byte arrays
package rsc_pkg;

  // ----------------------------------------------------------------
  // address byte and commands
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_CODE = 4'h6;
  localparam logic [2:0] CMD_STAT1 = 3'h0;
  localparam logic [2:0] CMD_STAT2 = 3'h1;
  localparam logic [2:0] CMD_CAL = 3'h2;
  localparam logic [2:0] CMD_TIME = 3'h3;
  localparam logic [2:0] CMD_ALMA = 3'h4;
  localparam logic [2:0] CMD_ALMB = 3'h5;
  localparam logic [2:0] CMD_TRIM = 3'h6;
  localparam logic [2:0] CMD_USER = 3'h7;

  // ----------------------------------------------------------------
  // mode_flags_register bit positions
  // ----------------------------------------------------------------
  localparam int S1_POWER_ON = 7;
  localparam int S1_SUPPLY_DROP = 6;
  localparam int S1_PIN_B = 5;
  localparam int S1_PIN_A = 4;
  localparam int S1_USER_HI = 3;
  localparam int S1_USER_LO = 2;
  localparam int S1_HOUR24 = 1;
  localparam int S1_INIT = 0;

  // ----------------------------------------------------------------
  // interrupt_mode_register bit positions
  // ----------------------------------------------------------------
  localparam int S2_TEST = 7;
  localparam int S2_B_ALARM = 6;
  localparam int S2_B_MINUTE = 5;
  localparam int S2_B_FREQ = 4;
  localparam int S2_CLK_OUT = 3;
  localparam int S2_A_ALARM = 2;
  localparam int S2_A_MINUTE = 1;
  localparam int S2_A_FREQ = 0;

  // ----------------------------------------------------------------
  // group sizes, writable masks, reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CAL_BYTES = 3'h7;
  localparam logic [2:0] TIME_BYTES = 3'h3;
  localparam logic [2:0] TIME_FIRST = 3'h4;
  localparam logic [2:0] ALARM_BYTES = 3'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // year, month, day, weekday, hour, minute, second (index 0 first)
  localparam logic [6:0][7:0] CAL_MASK =
    {8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h1f, 8'hff};
  // weekday, hour, minute; bit 7 is the match enable
  localparam logic [2:0][7:0] ALARM_MASK = {8'hff, 8'hff, 8'h87};
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic POWER_ON_RESET = 1'b1;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK,
    ST_READ, ST_READ_ACK, ST_IGNORE
  } rsc_state_t;

endpackage : rsc_pkg

// ==== tb/rsc_bus_master.sv ====
// Purpose: two-wire bus master model for the command decoder
// Assumes: data line pulled up; bus clock period 32 ref_clk (160 ns)
// Notes:   pins move on ref_clk falling edges only; sdaDrv 1 = released
`timescale 1ns/1ps
module rsc_bus_master (
  input wire logic ref_clk,
  input wire logic sdaLine,
  output logic sclPin,
  output logic sdaDrv
);
  initial begin
    sclPin = 1'b1;
    sdaDrv = 1'b1;
  end
  // ------------------------------------------------------------
  // bit and byte level
  // ------------------------------------------------------------
  task automatic waitCyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : waitCyc

  // data changes mid-low so it is stable across the whole high phase
  task automatic putBit(input logic b, output logic got);
    waitCyc(8);
    sdaDrv = b;
    waitCyc(8);
    sclPin = 1'b1;
    waitCyc(8);
    got = sdaLine;
    waitCyc(8);
    sclPin = 1'b0;
  endtask : putBit

  task automatic sendByte(input logic [7:0] d, input logic lsbFirst,
    output logic ack);
    logic g;
    for (int i = 0; i < 8; i++) begin
      putBit(lsbFirst ? d[i] : d[7 - i], g);
    end
    putBit(1'b1, g);
    ack = !g;
  endtask : sendByte

  task automatic getByte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 0; i < 8; i++) begin
      putBit(1'b1, g);
      d[i] = g;
    end
    putBit(last, g);
  endtask : getByte

  // ------------------------------------------------------------
  // one whole transaction, start to stop
  // ------------------------------------------------------------
  task automatic access(input logic [3:0] code, input logic [2:0] cmd,
    input logic rd, input int n, inout logic [55:0] d, output logic ack);
    logic g;
    waitCyc(8);
    sdaDrv = 1'b1;
    waitCyc(8);
    sclPin = 1'b1;
    waitCyc(8);
    sdaDrv = 1'b0;
    waitCyc(8);
    sclPin = 1'b0;
    sendByte({code, cmd, rd}, 1'b0, ack);
    for (int i = 0; i < n; i++) begin
      if (rd) begin
        getByte(i == n - 1, d[8*i+:8]);
      end else begin
        sendByte(d[8*i+:8], 1'b1, g);
        ack = ack & g;
      end
    end
    waitCyc(8);
    sdaDrv = 1'b0;
    waitCyc(8);
    sclPin = 1'b1;
    waitCyc(8);
    sdaDrv = 1'b1;
    waitCyc(16);
  endtask : access
endmodule : rsc_bus_master

// ==== tb/rsc_command_decode_sva.sv ====
// Purpose: port-level checks of the serial command decoder
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every instance of the decoder
`timescale 1ns/1ps
module rsc_command_decode_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclPin,
  input wire logic sdaOe,
  input wire logic pinAEvent,
  input wire logic pinBEvent,
  input wire logic supplyDrop,
  input wire logic deviceInit,
  input wire logic [7:0] modeFlags,
  input wire logic [7:0] interruptMode,
  input wire logic [55:0] calendarTime,
  input wire logic [23:0] pinAAlarm,
  input wire logic [23:0] pinBAlarm,
  input wire logic [7:0] userByte
);
  logic aMode;
  logic bMode;
  assign aMode = interruptMode[2:0] == 3'h4;
  assign bMode = interruptMode[6:4] == 3'h4;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  init_clears_a: assert property (deviceInit |=> !deviceInit &&
    modeFlags == 8'h00 && userByte == 8'h00 && calendarTime == 56'h0)
    else $error("registers not cleared after init");
  bit_zero_a: assert property (modeFlags[0] == 1'b0)
    else $error("init bit reads back set");
  cal_reserved_a: assert property (
    (calendarTime & ~56'h7f7f7f073f1fff) == 56'h0)
    else $error("calendar reserved bit set");
  alarm_reserved_a: assert property ((pinAAlarm & ~24'hffff87) ==
    24'h0 && (pinBAlarm & ~24'hffff87) == 24'h0)
    else $error("alarm reserved bit set");
  pin_a_set_a: assert property (pinAEvent && aMode |=> modeFlags[4])
    else $error("pin A flag not set");
  pin_a_cause_a: assert property ($rose(modeFlags[4]) |->
    $past(pinAEvent) && $past(aMode))
    else $error("pin A flag set without alarm event");
  pin_b_cause_a: assert property ($rose(modeFlags[5]) |->
    $past(pinBEvent) && $past(bMode))
    else $error("pin B flag set without alarm event");
  drop_set_a: assert property (supplyDrop |=> modeFlags[6])
    else $error("supply drop flag not set");
  power_on_a: assert property (!$rose(modeFlags[7]))
    else $error("power-on flag set again");
  sda_scl_low_a: assert property ($changed(sdaOe) |->
    !sclPin && !$past(sclPin, 2))
    else $error("data line moved while bus clock high");
  user_at_ack_a: assert property ($changed(userByte) |->
    $rose(sdaOe) || $past(deviceInit))
    else $error("user byte changed outside acknowledge");
  cover property (deviceInit);
  cover property ($rose(modeFlags[4]));
  cover property (aMode && $rose(sdaOe));
  cover property (supplyDrop);
endmodule : rsc_command_decode_sva

bind rsc_command_decode rsc_command_decode_sva rsc_command_decode_sva_i (
  .ref_clk(ref_clk), .rstn(rstn), .sclPin(sclPin), .sdaOe(sdaOe),
  .pinAEvent(pinAEvent), .pinBEvent(pinBEvent), .supplyDrop(supplyDrop),
  .deviceInit(deviceInit), .modeFlags(modeFlags),
  .interruptMode(interruptMode), .calendarTime(calendarTime),
  .pinAAlarm(pinAAlarm), .pinBAlarm(pinBAlarm), .userByte(userByte));

// ==== tb/rsc_command_decode_tb_top.sv ====
// Purpose: self-checking bench of the serial command decoder
// Assumes: 200 MHz ref_clk; bus master model on the far side
// Notes:   one task per scenario; events pulsed from the bench
`timescale 1ns/1ps
module rsc_command_decode_tb_top;
  logic ref_clk, rstn, sclPin, sdaDrv, sdaOut, sdaOe, deviceInit;
  logic pinAEvent, pinBEvent, supplyDrop;
  logic [7:0] modeFlags, interruptMode, pinAFreq, pinBFreq, rateTrim;
  logic [7:0] userByte;
  logic [55:0] calendarTime;
  logic [23:0] pinAAlarm, pinBAlarm;
  logic [55:0] d;
  logic ack;
  wire logic sdaLine;
  int error_cnt = 0;
  int checks = 0;
  int cycleCnt = 0;
  assign sdaLine = sdaOe ? sdaOut : sdaDrv;

  rsc_command_decode rsc_command_decode_i (.ref_clk(ref_clk),
    .rstn(rstn), .sclPin(sclPin), .sdaPin(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .pinAEvent(pinAEvent), .pinBEvent(pinBEvent),
    .supplyDrop(supplyDrop), .deviceInit(deviceInit),
    .modeFlags(modeFlags), .interruptMode(interruptMode),
    .calendarTime(calendarTime), .pinAAlarm(pinAAlarm),
    .pinBAlarm(pinBAlarm), .pinAFreq(pinAFreq), .pinBFreq(pinBFreq),
    .rateTrim(rateTrim), .userByte(userByte));
  rsc_bus_master rsc_bus_master_i (.ref_clk(ref_clk), .sdaLine(sdaLine),
    .sclPin(sclPin), .sdaDrv(sdaDrv));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // a hung handshake would otherwise stall the run forever
  always @(posedge ref_clk) begin
    cycleCnt++;
    if (cycleCnt == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [55:0] got, input logic [55:0] exp,
    input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [2:0] cmd, input int n,
    input logic [55:0] v);
    logic [55:0] t;
    t = v;
    rsc_bus_master_i.access(rsc_pkg::DEV_CODE, cmd, 1'b0, n, t, ack);
    cmp(ack, 1'b1, "write ack");
  endtask : wr

  task automatic rd(input logic [2:0] cmd, input int n);
    d = 56'h0;
    rsc_bus_master_i.access(rsc_pkg::DEV_CODE, cmd, 1'b1, n, d, ack);
    cmp(ack, 1'b1, "read ack");
  endtask : rd

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_mode_flags();
    cmp(modeFlags, 8'h80, "reset flags");
    wr(rsc_pkg::CMD_STAT1, 1, 56'hfe);
    cmp(modeFlags, 8'h8e, "flag write");
    rd(rsc_pkg::CMD_STAT1, 1);
    cmp(d[7:0], 8'h8e, "flag read");
    rd(rsc_pkg::CMD_STAT1, 1);
    cmp(d[7:0], 8'h0e, "flag reread");
  endtask : t_mode_flags

  task automatic t_foreign();
    d = 56'h11;
    rsc_bus_master_i.access(4'h7, rsc_pkg::CMD_USER, 1'b0, 1, d, ack);
    cmp(ack, 1'b0, "foreign ack");
    cmp(userByte, 8'h00, "foreign write");
    rsc_bus_master_i.access(4'he, rsc_pkg::CMD_USER, 1'b1, 1, d, ack);
    cmp(d[7:0], 8'hff, "foreign read");
  endtask : t_foreign

  task automatic t_calendar();
    wr(rsc_pkg::CMD_CAL, 7, 56'hffffffffffffff);
    cmp(calendarTime, 56'h7f7f7f073f1fff, "cal masks");
    wr(rsc_pkg::CMD_TIME, 3, 56'h563452);
    cmp(calendarTime[55:32], 24'h563452, "time write");
    rd(rsc_pkg::CMD_CAL, 7);
    cmp(d, 56'h563452073f1fff, "cal read");
  endtask : t_calendar

  task automatic pulse_events();
    @(negedge ref_clk);
    {pinAEvent, pinBEvent, supplyDrop} = 3'h7;
    @(negedge ref_clk);
    {pinAEvent, pinBEvent, supplyDrop} = 3'h0;
    @(negedge ref_clk);
  endtask : pulse_events

  task automatic t_alarm();
    wr(rsc_pkg::CMD_STAT2, 1, 56'h14);
    cmp(interruptMode, 8'h14, "int mode");
    wr(rsc_pkg::CMD_ALMA, 3, 56'hffffff);
    cmp(pinAAlarm, 24'hffff87, "alarm A");
    wr(rsc_pkg::CMD_ALMB, 1, 56'he5);
    cmp(pinBFreq, 8'he5, "freq B");
    cmp(pinBAlarm, 24'h0, "alarm B kept");
    rd(rsc_pkg::CMD_ALMB, 1);
    cmp(d[7:0], 8'he5, "freq B read");
    pulse_events();
    cmp(modeFlags, 8'h5e, "event flags");
    rd(rsc_pkg::CMD_STAT1, 1);
    cmp(d[7:0], 8'h5e, "event read");
    cmp(modeFlags, 8'h0e, "event cleared");
    // swap roles: pin A to frequency mode, pin B to alarm mode
    wr(rsc_pkg::CMD_STAT2, 1, 56'h41);
    wr(rsc_pkg::CMD_ALMA, 1, 56'h3a);
    cmp(pinAFreq, 8'h3a, "freq A");
    pulse_events();
    cmp(modeFlags, 8'h6e, "pin B flag");
  endtask : t_alarm

  task automatic t_plain();
    wr(rsc_pkg::CMD_TRIM, 1, 56'ha5);
    wr(rsc_pkg::CMD_USER, 1, 56'h3c);
    rd(rsc_pkg::CMD_TRIM, 1);
    cmp(d[7:0], 8'ha5, "trim");
    rd(rsc_pkg::CMD_USER, 1);
    cmp(d[7:0], 8'h3c, "user");
  endtask : t_plain

  task automatic t_init();
    wr(rsc_pkg::CMD_STAT1, 1, 56'h01);
    cmp({modeFlags, userByte, rateTrim}, 24'h0, "init");
    cmp(calendarTime, 56'h0, "init cal");
  endtask : t_init

  initial begin
    rstn = 1'b0;
    pinAEvent = 1'b0;
    pinBEvent = 1'b0;
    supplyDrop = 1'b0;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_mode_flags();
    t_foreign();
    t_calendar();
    t_alarm();
    t_plain();
    t_init();
    print_verdict();
  end
endmodule : rsc_command_decode_tb_top
